// ==== inc/sdf_map.svh ====
// Purpose: named constants of the start delimiter receiver
// Assumes: included by bare name from design files
// Notes: definitions only
`ifndef SDF_MAP_SVH
`define SDF_MAP_SVH

// ----------------------------------------
// counts and fixed patterns
// ----------------------------------------
`define SDF_IDLE_RUN 3'h6
`define SDF_PRE_NIB 4'h5
`define SDF_TRI_FIRST 3'h5
`define SDF_TRI_SECOND 3'h2
`define SDF_TRI_W 3
`define SDF_NIB_W 4

`endif

// ==== inc/sdf_pkg.sv ====
// Purpose: types of the start delimiter receiver
// Assumes: nothing
// Notes: symbol classes come from the ternary decoder upstream
package sdf_pkg;

    // ----------------------------------------
    // received symbol class
    // ----------------------------------------
    typedef enum logic [2:0] {
        KIND_DATA,
        KIND_IDLE,
        KIND_SSD1,
        KIND_SSD2,
        KIND_SSD3,
        KIND_BAD
    } sdf_kind_t;

    // ----------------------------------------
    // receive states
    // ----------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CHK2,
        ST_CHK3,
        ST_SSD,
        ST_FIRST,
        ST_SECOND,
        ST_DATA,
        ST_BAD
    } sdf_state_t;

endpackage

// ==== src/sdf_pack.sv ====
// Purpose: repacks received tribits into nibbles, lsb first
// Assumes: push and clear come from the same clock
// Notes: emits a one-cycle nibble strobe
`timescale 1ns/1ps
`include "sdf_map.svh"

module sdf_pack #(
    parameter int TW = `SDF_TRI_W,
    parameter int NW = `SDF_NIB_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // tribit side
    input wire logic clear,
    input wire logic push,
    input wire logic [TW-1:0] tri_in,
    // nibble side
    output logic nib_stb,
    output logic [NW-1:0] nib
);
    localparam int BW = TW + NW;
    localparam int CW = $clog2(BW + 1);

    logic [BW-1:0] buf_reg;
    logic [CW-1:0] cnt_reg;
    logic [BW-1:0] merged;
    logic [CW-1:0] fill;

    // ----------------------------------------
    // merge new tribit above the leftover bits
    // ----------------------------------------
    always_comb begin
        merged = buf_reg | (BW'(tri_in) << cnt_reg);
        fill = cnt_reg + CW'(TW);
    end

    always_ff @(posedge clk) begin
        if (sys_rst || clear) begin
            buf_reg <= '0;
            cnt_reg <= '0;
        end else if (push) begin
            if (fill >= CW'(NW)) begin
                buf_reg <= merged >> NW;
                cnt_reg <= fill - CW'(NW);
            end else begin
                buf_reg <= merged;
                cnt_reg <= fill;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            nib_stb <= 1'b0;
            nib <= '0;
        end else begin
            nib_stb <= push && !clear && (fill >= CW'(NW));
            if (push && fill >= CW'(NW)) begin
                nib <= merged[NW-1:0];
            end
        end
    end
endmodule

// ==== src/sdf_rx.sv ====
// Purpose: receive start-of-stream delimiter state machine toward the MAC
// Assumes: one symbol class per sym_stb; link_ok from logic on clk
// Notes: end of stream is taken as the first idle symbol in data
//
// What this block does
// - with link up and idle arriving, stay in IDLE, no data valid
// - after delimiter, data valid with 0101 twice, then received nibbles
// - in IDLE, a symbol neither SSD1 nor idle raises receive error
// - in CHECK SSD2, SSD2 moves on to CHECK SSD3
// - in CHECK SSD2, anything else goes to BAD SSD with error
// - in CHECK SSD3, SSD3 moves on to SSD
// - in CHECK SSD3, anything else goes to BAD SSD with error
// - SSD always advances to FIRST SSD on the next symbol
// - FIRST SSD shows data valid and 0101 whatever symbol came
// - BAD SSD holds error until the idle check is met
// - idle check is met after six consecutive valid idle symbols
// - entering FIRST SSD loads tribit 101, then on to SECOND SSD
// - entering SECOND SSD loads tribit 010, then on to DATA
`timescale 1ns/1ps
`include "sdf_map.svh"

module sdf_rx (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // symbol side
    input wire logic link_ok,
    input wire logic sym_stb,
    input wire sdf_pkg::sdf_kind_t sym_kind,
    input wire logic [2:0] sym_data,
    // media independent receive side
    output logic rx_dv,
    output logic rx_er,
    output logic [3:0] rxd
);
    sdf_pkg::sdf_state_t state_reg;
    sdf_pkg::sdf_state_t state_next;
    logic [2:0] idle_cnt_reg;
    logic check_idle;
    logic rx_dv_reg;
    logic rx_er_reg;
    logic [3:0] rxd_reg;
    logic push_en;
    logic [2:0] push_tri;
    logic nib_stb;
    logic [3:0] nib;
    logic is_idle;

    assign is_idle = (sym_kind == sdf_pkg::KIND_IDLE);

    // ----------------------------------------
    // run of consecutive valid idle symbols
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst || !link_ok) begin
            idle_cnt_reg <= '0;
        end else if (sym_stb) begin
            if (!is_idle) begin
                idle_cnt_reg <= '0;
            end else if (idle_cnt_reg != `SDF_IDLE_RUN) begin
                idle_cnt_reg <= idle_cnt_reg + 3'h1;
            end
        end
    end

    // counts the symbol now arriving so six idles free the machine at once
    assign check_idle = sym_stb && is_idle && (idle_cnt_reg >= (`SDF_IDLE_RUN - 3'h1));

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        state_next = state_reg;
        if (!link_ok) begin
            state_next = sdf_pkg::ST_IDLE;
        end else if (sym_stb) begin
            unique case (state_reg)
                sdf_pkg::ST_IDLE: begin
                    if (sym_kind == sdf_pkg::KIND_SSD1) begin
                        state_next = sdf_pkg::ST_CHK2;
                    end else if (!is_idle) begin
                        state_next = sdf_pkg::ST_BAD;
                    end
                end
                sdf_pkg::ST_CHK2: begin
                    if (sym_kind == sdf_pkg::KIND_SSD2) begin
                        state_next = sdf_pkg::ST_CHK3;
                    end else begin
                        state_next = sdf_pkg::ST_BAD;
                    end
                end
                sdf_pkg::ST_CHK3: begin
                    if (sym_kind == sdf_pkg::KIND_SSD3) begin
                        state_next = sdf_pkg::ST_SSD;
                    end else begin
                        state_next = sdf_pkg::ST_BAD;
                    end
                end
                sdf_pkg::ST_SSD: state_next = sdf_pkg::ST_FIRST;
                sdf_pkg::ST_FIRST: state_next = sdf_pkg::ST_SECOND;
                sdf_pkg::ST_SECOND: state_next = sdf_pkg::ST_DATA;
                sdf_pkg::ST_DATA: begin
                    if (is_idle) begin
                        state_next = sdf_pkg::ST_IDLE;
                    end
                end
                sdf_pkg::ST_BAD: begin
                    if (check_idle) begin
                        state_next = sdf_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= sdf_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------
    // tribits fed to the nibble packer
    // ----------------------------------------
    always_comb begin
        push_en = 1'b0;
        push_tri = sym_data;
        if (link_ok && sym_stb) begin
            unique case (state_reg)
                sdf_pkg::ST_SSD: begin
                    push_en = 1'b1;
                    push_tri = `SDF_TRI_FIRST;
                end
                sdf_pkg::ST_FIRST: begin
                    push_en = 1'b1;
                    push_tri = `SDF_TRI_SECOND;
                end
                sdf_pkg::ST_SECOND: push_en = 1'b1;
                sdf_pkg::ST_DATA: push_en = !is_idle;
                default: push_en = 1'b0;
            endcase
        end
    end

    // packer is flushed while the receiver sits in IDLE
    sdf_pack #(
        .TW(`SDF_TRI_W),
        .NW(`SDF_NIB_W)
    ) u_pack (
        .clk(clk),
        .sys_rst(sys_rst),
        .clear(state_reg == sdf_pkg::ST_IDLE),
        .push(push_en),
        .tri_in(push_tri),
        .nib_stb(nib_stb),
        .nib(nib)
    );

    // ----------------------------------------
    // receive outputs
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rx_dv_reg <= 1'b0;
            rx_er_reg <= 1'b0;
        end else begin
            rx_dv_reg <= (state_next == sdf_pkg::ST_FIRST) || (state_next == sdf_pkg::ST_SECOND)
                || (state_next == sdf_pkg::ST_DATA);
            rx_er_reg <= (state_next == sdf_pkg::ST_BAD);
        end
    end

    // preamble nibble is forced through FIRST SSD and SECOND SSD, the packer fills the rest
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rxd_reg <= '0;
        end else if (state_next == sdf_pkg::ST_FIRST || state_next == sdf_pkg::ST_SECOND) begin
            rxd_reg <= `SDF_PRE_NIB;
        end else if (state_next != sdf_pkg::ST_DATA) begin
            rxd_reg <= '0;
        end else if (nib_stb) begin
            rxd_reg <= nib;
        end
    end

    assign rx_dv = rx_dv_reg;
    assign rx_er = rx_er_reg;
    assign rxd = rxd_reg;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_idle_quiet: assert property (state_reg == sdf_pkg::ST_IDLE && link_ok && sym_stb && is_idle
        |=> state_reg == sdf_pkg::ST_IDLE && !rx_dv)
        else $error("idle left or data valid on idle");
    a_idle_error: assert property (state_reg == sdf_pkg::ST_IDLE && link_ok && sym_stb
        && !is_idle && sym_kind != sdf_pkg::KIND_SSD1 |=> rx_er && state_reg == sdf_pkg::ST_BAD)
        else $error("bad symbol in idle not flagged");
    a_ssd1_enter: assert property (state_reg == sdf_pkg::ST_IDLE && link_ok && sym_stb
        && sym_kind == sdf_pkg::KIND_SSD1 |=> state_reg == sdf_pkg::ST_CHK2 && !rx_dv && !rx_er)
        else $error("ssd1 not taken quietly");
    a_chk2_path: assert property (state_reg == sdf_pkg::ST_CHK2 && link_ok && sym_stb
        |=> (state_reg == sdf_pkg::ST_CHK3) == ($past(sym_kind) == sdf_pkg::KIND_SSD2)
        && (rx_er != (state_reg == sdf_pkg::ST_CHK3)))
        else $error("check ssd2 went wrong way");
    a_chk3_path: assert property (state_reg == sdf_pkg::ST_CHK3 && link_ok && sym_stb
        |=> (state_reg == sdf_pkg::ST_SSD) == ($past(sym_kind) == sdf_pkg::KIND_SSD3)
        && (rx_er != (state_reg == sdf_pkg::ST_SSD)))
        else $error("check ssd3 went wrong way");
    a_ssd_first: assert property (state_reg == sdf_pkg::ST_SSD && link_ok && sym_stb
        |=> state_reg == sdf_pkg::ST_FIRST && rx_dv && rxd == `SDF_PRE_NIB)
        else $error("ssd did not open the frame");
    a_first_tribit: assert property (state_reg == sdf_pkg::ST_FIRST && link_ok && sym_stb
        |=> nib_stb && nib == `SDF_PRE_NIB)
        else $error("forced tribits did not pack to the preamble nibble");
    a_second_tribit: assert property (state_reg == sdf_pkg::ST_FIRST && link_ok && sym_stb
        |-> push_en && push_tri == `SDF_TRI_SECOND ##1 state_reg == sdf_pkg::ST_SECOND && rx_dv && rxd == `SDF_PRE_NIB)
        else $error("second preamble step wrong");
    a_bad_hold: assert property (state_reg == sdf_pkg::ST_BAD |-> rx_er)
        else $error("error dropped in bad ssd");
    a_idle_run: assert property (state_reg == sdf_pkg::ST_BAD && link_ok && sym_stb && is_idle
        && idle_cnt_reg == (`SDF_IDLE_RUN - 3'h1) |=> state_reg == sdf_pkg::ST_IDLE && !rx_er)
        else $error("six idles did not clear bad ssd");

    c_frame: cover property (state_reg == sdf_pkg::ST_SECOND ##1 state_reg == sdf_pkg::ST_DATA);
    c_bad_chk2: cover property (state_reg == sdf_pkg::ST_CHK2 ##1 state_reg == sdf_pkg::ST_BAD);
    c_bad_chk3: cover property (state_reg == sdf_pkg::ST_CHK3 ##1 state_reg == sdf_pkg::ST_BAD);
    c_recover: cover property (state_reg == sdf_pkg::ST_BAD ##1 state_reg == sdf_pkg::ST_IDLE);
endmodule

// ==== tb/sdf_link_model.sv ====
// Purpose: far-side symbol source feeding the delimiter receiver
// Assumes: commanded by the bench through its tasks
// Notes: every symbol is one strobe followed by one quiet cycle
`timescale 1ns/1ps

module sdf_link_model (
    // clock
    input wire logic clk,
    // symbol side
    output logic link_ok,
    output logic sym_stb,
    output sdf_pkg::sdf_kind_t sym_kind,
    output logic [2:0] sym_data
);
    initial begin
        link_ok = 1'b0;
        sym_stb = 1'b0;
        sym_kind = sdf_pkg::KIND_IDLE;
        sym_data = 3'h0;
    end

    // ----------------------------------------
    // symbol and link tasks
    // ----------------------------------------
    // qualifiers are scrambled once the strobe drops, so a stale value never looks valid
    task automatic send(input sdf_pkg::sdf_kind_t k, input logic [2:0] d);
        @(posedge clk);
        sym_stb <= 1'b1;
        sym_kind <= k;
        sym_data <= d;
        @(posedge clk);
        sym_stb <= 1'b0;
        sym_data <= ~d;
        sym_kind <= (k == sdf_pkg::KIND_BAD) ? sdf_pkg::KIND_DATA : sdf_pkg::KIND_BAD;
    endtask

    task automatic link(input logic up);
        @(posedge clk);
        link_ok <= up;
    endtask
endmodule

// ==== tb/tb_top.sv ====
// Purpose: self-checking bench of the start delimiter receiver
// Assumes: rx_dv, rx_er and preamble rxd follow one edge after each taken strobe; data nibbles on rxd one edge later
// Notes: no open waits; every delay is a fixed figure
`timescale 1ns/1ps

module tb_top;
    logic clk;
    logic sys_rst;
    logic link_ok;
    logic sym_stb;
    sdf_pkg::sdf_kind_t sym_kind;
    logic [2:0] sym_data;
    logic rx_dv;
    logic rx_er;
    logic [3:0] rxd;
    int num_errors = 0;
    int checked = 0;

    initial clk = 1'b0;
    always #25 clk = ~clk;

    sdf_link_model u_sdf_link_model (.clk(clk), .link_ok(link_ok), .sym_stb(sym_stb),
        .sym_kind(sym_kind), .sym_data(sym_data));
    sdf_rx u_sdf_rx (.clk(clk), .sys_rst(sys_rst), .link_ok(link_ok), .sym_stb(sym_stb),
        .sym_kind(sym_kind), .sym_data(sym_data), .rx_dv(rx_dv), .rx_er(rx_er), .rxd(rxd));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic put(input sdf_pkg::sdf_kind_t k, input logic [2:0] d);
        u_sdf_link_model.send(k, d);
        #1;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic run_idle();
        repeat (8) begin
            put(sdf_pkg::KIND_IDLE, 3'h0);
            chk("rx_dv idle", 4'h0, {3'h0, rx_dv});
            chk("rx_er idle", 4'h0, {3'h0, rx_er});
        end
    endtask

    // follow symbol after the delimiter must not matter
    task automatic run_frame(input sdf_pkg::sdf_kind_t fk, input logic [2:0] fd);
        put(sdf_pkg::KIND_SSD1, 3'h0);
        chk("rx_dv chk2", 4'h0, {3'h0, rx_dv});
        chk("rx_er chk2", 4'h0, {3'h0, rx_er});
        put(sdf_pkg::KIND_SSD2, 3'h0);
        chk("rx_er chk3", 4'h0, {3'h0, rx_er});
        put(sdf_pkg::KIND_SSD3, 3'h0);
        chk("rx_dv ssd", 4'h0, {3'h0, rx_dv});
        put(fk, fd);
        chk("rx_dv first", 4'h1, {3'h0, rx_dv});
        chk("rxd first", 4'h5, rxd);
        put(sdf_pkg::KIND_DATA, 3'h2);
        chk("rxd second", 4'h5, rxd);
        put(sdf_pkg::KIND_DATA, 3'h6);
        repeat (2) @(posedge clk);
        #1;
        // bits 1,0 left from the 010 tribit, then 0,1 of the data
        chk("rxd data", 4'h9, rxd);
        chk("rx_dv data", 4'h1, {3'h0, rx_dv});
        put(sdf_pkg::KIND_IDLE, 3'h0);
        chk("rx_dv end", 4'h0, {3'h0, rx_dv});
    endtask

    // error kind must not be idle, or it would count toward the idle run
    task automatic run_bad(input int n, input sdf_pkg::sdf_kind_t ek);
        if (n > 0) put(sdf_pkg::KIND_SSD1, 3'h0);
        if (n > 1) put(sdf_pkg::KIND_SSD2, 3'h0);
        put(ek, 3'h1);
        chk("rx_er bad", 4'h1, {3'h0, rx_er});
        repeat (5) begin
            put(sdf_pkg::KIND_IDLE, 3'h0);
            chk("rx_er held", 4'h1, {3'h0, rx_er});
        end
        put(sdf_pkg::KIND_IDLE, 3'h0);
        chk("rx_er cleared", 4'h0, {3'h0, rx_er});
        chk("rx_dv cleared", 4'h0, {3'h0, rx_dv});
    endtask

    task automatic run_link_loss();
        put(sdf_pkg::KIND_SSD1, 3'h0);
        put(sdf_pkg::KIND_SSD2, 3'h0);
        put(sdf_pkg::KIND_SSD3, 3'h0);
        put(sdf_pkg::KIND_DATA, 3'h0);
        u_sdf_link_model.link(1'b0);
        @(posedge clk);
        #1;
        chk("rx_dv link down", 4'h0, {3'h0, rx_dv});
        chk("rx_er link down", 4'h0, {3'h0, rx_er});
        u_sdf_link_model.link(1'b1);
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        sys_rst = 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        u_sdf_link_model.link(1'b1);
        #1;
        chk("rxd reset", 4'h0, rxd);
        chk("rx_dv reset", 4'h0, {3'h0, rx_dv});
        chk("rx_er reset", 4'h0, {3'h0, rx_er});
        run_idle();
        run_frame(sdf_pkg::KIND_DATA, 3'h2);
        run_frame(sdf_pkg::KIND_DATA, 3'h0);
        run_frame(sdf_pkg::KIND_SSD1, 3'h0);
        run_bad(0, sdf_pkg::KIND_DATA);
        run_bad(0, sdf_pkg::KIND_BAD);
        run_bad(0, sdf_pkg::KIND_SSD2);
        run_bad(0, sdf_pkg::KIND_SSD3);
        run_bad(1, sdf_pkg::KIND_DATA);
        run_bad(1, sdf_pkg::KIND_SSD1);
        run_bad(2, sdf_pkg::KIND_DATA);
        run_bad(2, sdf_pkg::KIND_SSD2);
        run_link_loss();
        run_frame(sdf_pkg::KIND_DATA, 3'h5);
        wrap_up();
    end
endmodule
